//--- hdl/wsp_parser.sv
/*
  Weight stream slice parser. Reads the compiled weight stream a byte at
  a time, splits it into slices, decodes each slice header and hands the
  remaining bits of a slice (extended palette header and chunks) one at
  a time to a chunk decoder that sits behind it.
  Assumes the byte source and the chunk decoder run on ref_clk_i, and
  that the chunk decoder says when it has taken a slice's last bit.
*/
`default_nettype none

module wsp_parser
  import wsp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [WSP_OFS_W-1:0] second_weight_stream_offset_cmd_i,
  input wire logic [WSP_WLEN_W-1:0] second_weight_stream_length_cmd_i,
  input wire logic [WSP_OFS_W-1:0] second_scale_stream_offset_cmd_i,
  input wire logic [WSP_SLEN_W-1:0] second_scale_stream_length_cmd_i,
  output logic [WSP_OFS_W-1:0] fetch_addr_o,
  output logic byte_ready_o,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic chunk_bit_o,
  output logic chunk_valid_o,
  input wire logic chunk_ready_i,
  input wire logic slice_done_i,
  output wsp_hdr_t hdr_o,
  output logic slice_start_o,
  output logic pal_reload_o,
  output logic [WSP_OFS_W-1:0] scale_offset_o,
  output logic [WSP_SLEN_W-1:0] scale_length_o,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [2:0] err_code_o
);

  // Divisor one shifted left by a code, used for both divisors
  // Reserved codes still give a value; the error path decides
  function automatic logic [7:0] div_of(input logic [2:0] code);
    div_of = 8'h01 << code;
  endfunction

  wsp_regs_t r; // Registered state
  wsp_regs_t r_nxt; // Next state

  logic have_bit; // A stream bit is ready in byte_buf
  logic cur_bit; // The next stream bit
  logic eos; // All bytes taken and buffer empty
  logic need_bits; // State consumes stream bits
  logic take; // A header or pad bit is consumed this cycle
  logic [14:0] elem; // Element with the current bit merged in
  logic elem_full; // Element completes with this bit

  // Bit reader view, element assembly and next state in one process
  // The byte buffer always holds unread bits at its low end, so
  // bit 0 is the next stream bit whatever the element being built.
  // Old high bits of acc are left in place between elements; each
  // element only ever reads the bits it has just filled.
  always_comb begin
    have_bit = (r.bits_left != 4'h0);
    cur_bit = r.byte_buf[0];
    eos = !have_bit && (r.fetched == r.cmd.wgt_len);
    need_bits = (r.state != WSP_IDLE) && (r.state != WSP_CHUNK || !r.slot_valid);
    take = have_bit && (r.state != WSP_IDLE) && (r.state != WSP_CHUNK);
    elem = r.acc;
    elem[r.acc_cnt] = cur_bit;
    elem_full = 1'b0;
    case (r.state)
      WSP_ZDIV: elem_full = (r.acc_cnt == WSP_ZDIV_BITS - 4'h1);
      WSP_LEN: elem_full = (r.acc_cnt == WSP_SLICELEN_BITS - 4'h1);
      WSP_WDIV: elem_full = (r.acc_cnt == WSP_WDIV_BITS - 4'h1);
      default: elem_full = 1'b1; // Single-bit elements
    endcase

    // Next-state logic for the whole parser
    // Pulses default low, everything else holds
    r_nxt = r;
    r_nxt.slice_start = 1'b0;
    r_nxt.pal_reload = 1'b0;
    r_nxt.done = 1'b0;

    // Byte intake, one handshake then ready drops
    // Never meets a bit take: ready only stands with an empty buffer
    if (r.byte_ready && byte_valid_i) begin
      r_nxt.byte_buf = byte_i;
      r_nxt.bits_left = WSP_BYTE_BITS;
      r_nxt.fetched = r.fetched + 32'h1;
      r_nxt.fetch_addr = r.fetch_addr + 48'h1;
    end

    // Consume one header or padding bit, low end first
    if (take) begin
      r_nxt.byte_buf = {1'b0, r.byte_buf[7:1]};
      r_nxt.bits_left = r.bits_left - 4'h1;
      r_nxt.acc = elem;
      r_nxt.acc_cnt = elem_full ? 4'h0 : r.acc_cnt + 4'h1;
    end

    // Chunk decoder takes the offered bit
    if (r.slot_valid && chunk_ready_i) begin
      r_nxt.slot_valid = 1'b0;
    end

    case (r.state)
      WSP_IDLE: begin
        // Latch stream locations from the command issuer
        if (start_i) begin
          r_nxt = '0;
          r_nxt.state = WSP_ZDIV;
          r_nxt.cmd.wgt_ofs = second_weight_stream_offset_cmd_i;
          r_nxt.cmd.wgt_len = second_weight_stream_length_cmd_i;
          r_nxt.cmd.scl_ofs = second_scale_stream_offset_cmd_i;
          r_nxt.cmd.scl_len = second_scale_stream_length_cmd_i;
          r_nxt.fetch_addr = second_weight_stream_offset_cmd_i;
          r_nxt.first_slice = 1'b1;
          r_nxt.busy = 1'b1;
        end
      end
      WSP_ZDIV: begin
        if (eos && r.acc_cnt == 4'h0) begin
          // End of stream only counts at the loop head
          r_nxt.state = WSP_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
          if ((r.cmd.wgt_len[3:0] & WSP_WORD_BYTE_MASK) != 4'h0) begin
            r_nxt.err = 1'b1;
            r_nxt.err_code = WSP_ERR_ALIGN;
          end
        end else if (take && elem_full) begin
          r_nxt.work.zdiv = elem[2:0];
          r_nxt.work.zrun_div = div_of(elem[2:0]);
          r_nxt.work.zrun_on = (elem[2:0] <= WSP_ZDIV_MAX_SHIFT);
          if (elem[2:0] == WSP_ZDIV_ALIGN) begin
            r_nxt.state = WSP_PAD;
          end else if (elem[2:0] > WSP_ZDIV_MAX_SHIFT && elem[2:0] != WSP_ZDIV_NO_ZRUN) begin
            r_nxt.err = 1'b1;
            r_nxt.err_code = WSP_ERR_ZDIV;
            r_nxt.state = WSP_IDLE;
            r_nxt.busy = 1'b0;
            r_nxt.done = 1'b1;
          end else begin
            r_nxt.state = WSP_LEN;
          end
        end
      end
      WSP_PAD: begin
        // Byte boundary reached when the buffer is spent
        if (!have_bit) begin
          r_nxt.state = WSP_ZDIV;
          r_nxt.acc_cnt = 4'h0;
        end else if (cur_bit != WSP_PAD_BIT && !r.err) begin
          r_nxt.err = 1'b1;
          r_nxt.err_code = WSP_ERR_PAD;
        end
      end
      WSP_LEN: begin
        if (take && elem_full) begin
          r_nxt.work.slice_length = {1'b0, elem} + 16'h0001;
          r_nxt.state = WSP_WDIV;
        end
      end
      WSP_WDIV: begin
        if (take && elem_full) begin
          r_nxt.work.wdiv = elem[2:0];
          r_nxt.work.w_div = div_of(elem[2:0]);
          r_nxt.work.w_uncomp = (elem[2:0] == WSP_WDIV_UNCOMP);
          if (elem[2:0] > WSP_WDIV_MAX_SHIFT && elem[2:0] != WSP_WDIV_UNCOMP && !r.err) begin
            r_nxt.err = 1'b1;
            r_nxt.err_code = WSP_ERR_WDIV;
          end
          r_nxt.state = WSP_TRUNC;
        end
      end
      WSP_TRUNC: begin
        if (take) begin
          r_nxt.work.wtrunc = cur_bit;
          r_nxt.state = WSP_NEWPAL;
        end
      end
      WSP_NEWPAL: begin
        if (take) begin
          // Header complete: publish it for the whole slice
          r_nxt.hdr = r.work;
          r_nxt.hdr.newpal = cur_bit;
          r_nxt.slice_start = 1'b1;
          r_nxt.pal_reload = cur_bit;
          r_nxt.first_slice = 1'b0;
          if (r.first_slice && !cur_bit && !r.err) begin
            r_nxt.err = 1'b1;
            r_nxt.err_code = WSP_ERR_PAL;
          end
          r_nxt.state = WSP_CHUNK;
        end
      end
      WSP_CHUNK: begin
        // Decoder consumes palette and chunk bits at its own pace
        // One bit is offered ahead; only the decoder knows where the
        // slice ends, so a prefetched bit may have to go back.
        // The top of byte_buf is zero once read, so shifting the bit
        // back in loses nothing.
        if (slice_done_i) begin
          // Give back a bit offered but not taken
          if (r.slot_valid && !chunk_ready_i) begin
            r_nxt.byte_buf = {r.byte_buf[6:0], r.slot_bit};
            r_nxt.bits_left = r.bits_left + 4'h1;
          end
          r_nxt.slot_valid = 1'b0;
          r_nxt.acc_cnt = 4'h0;
          r_nxt.state = WSP_ZDIV;
        end else if (have_bit && (!r.slot_valid || chunk_ready_i)) begin
          r_nxt.slot_bit = cur_bit;
          r_nxt.slot_valid = 1'b1;
          r_nxt.byte_buf = {1'b0, r.byte_buf[7:1]};
          r_nxt.bits_left = r.bits_left - 4'h1;
        end
      end
      default: r_nxt.state = WSP_IDLE;
    endcase

    // Running dry inside an element ends the stream in error
    // Padding may run dry safely: the buffer ends on a byte boundary.
    // A byte landing in this very cycle still rescues the element.
    if (r.state != WSP_IDLE && r.state != WSP_ZDIV && r.state != WSP_PAD && eos
        && !(r.byte_ready && byte_valid_i)) begin
      r_nxt.state = WSP_IDLE;
      r_nxt.busy = 1'b0;
      r_nxt.done = 1'b1;
      r_nxt.slot_valid = 1'b0;
      r_nxt.err = 1'b1;
      r_nxt.err_code = WSP_ERR_TRUNC;
    end else if (r.state == WSP_ZDIV && r.acc_cnt != 4'h0 && eos) begin
      r_nxt.state = WSP_IDLE;
      r_nxt.busy = 1'b0;
      r_nxt.done = 1'b1;
      r_nxt.err = 1'b1;
      r_nxt.err_code = WSP_ERR_TRUNC;
    end

    // Ask for a byte only when the buffer will be empty and bits are wanted
    // Computed from the next state so ready is itself a flop output.
    // Padding never fetches: it only spends the bits already held.
    // A held chunk bit blocks the fetch, keeping room for a give-back.
    r_nxt.byte_ready = (r_nxt.bits_left == 4'h0) && (r_nxt.state != WSP_IDLE)
                       && (r_nxt.state != WSP_PAD)
                       && (r_nxt.state != WSP_CHUNK || !r_nxt.slot_valid)
                       && (r_nxt.fetched != r_nxt.cmd.wgt_len);
  end

  // Parser state register
  // Synchronous reset clears every field, outputs included
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // Outputs straight from state flops
  // No output logic after the register, so no glitches reach pins
  assign fetch_addr_o = r.fetch_addr;
  assign byte_ready_o = r.byte_ready;
  assign chunk_bit_o = r.slot_bit;
  assign chunk_valid_o = r.slot_valid;
  assign hdr_o = r.hdr;
  assign slice_start_o = r.slice_start;
  assign pal_reload_o = r.pal_reload;
  assign scale_offset_o = r.cmd.scl_ofs;
  assign scale_length_o = r.cmd.scl_len;
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign err_o = r.err;
  assign err_code_o = r.err_code;

endmodule

`default_nettype wire

//--- hdl/wsp_pkg.sv
/*
  Package for the weight stream slice parser: field widths, syntax
  element lengths, code values, states and the carried structs.
  Assumes a single core clock and a synchronous active-high reset.
*/
`default_nettype none

package wsp_pkg;

  // Command payload widths
  localparam int unsigned WSP_OFS_W = 48; // Byte offset in a memory region
  localparam int unsigned WSP_WLEN_W = 32; // Weight stream byte length
  localparam int unsigned WSP_SLEN_W = 20; // Scale stream byte length

  // Syntax element lengths in bits
  localparam logic [3:0] WSP_ZDIV_BITS = 4'h3;
  localparam logic [3:0] WSP_SLICELEN_BITS = 4'hF;
  localparam logic [3:0] WSP_WDIV_BITS = 4'h3;

  // Bit reader figures
  localparam logic [3:0] WSP_BYTE_BITS = 4'h8;
  localparam logic [3:0] WSP_WORD_BYTE_MASK = 4'hF; // 128-bit word = 16 bytes

  // Zero-run divisor codes
  localparam logic [2:0] WSP_ZDIV_MAX_SHIFT = 3'h3;
  localparam logic [2:0] WSP_ZDIV_NO_ZRUN = 3'h6;
  localparam logic [2:0] WSP_ZDIV_ALIGN = 3'h7;

  // Weight divisor codes
  localparam logic [2:0] WSP_WDIV_MAX_SHIFT = 3'h5;
  localparam logic [2:0] WSP_WDIV_UNCOMP = 3'h7;

  // Padding bit value
  localparam logic WSP_PAD_BIT = 1'b1;

  // Error codes
  localparam logic [2:0] WSP_ERR_NONE = 3'h0;
  localparam logic [2:0] WSP_ERR_ZDIV = 3'h1; // Reserved zero-run code
  localparam logic [2:0] WSP_ERR_WDIV = 3'h2; // Reserved weight divisor
  localparam logic [2:0] WSP_ERR_PAD = 3'h3; // Padding bit was zero
  localparam logic [2:0] WSP_ERR_PAL = 3'h4; // First slice without new palette
  localparam logic [2:0] WSP_ERR_TRUNC = 3'h5; // Stream ended inside an element
  localparam logic [2:0] WSP_ERR_ALIGN = 3'h6; // End not on 128-bit boundary

  // Parser states
  typedef enum logic [3:0] {
    WSP_IDLE,
    WSP_ZDIV,
    WSP_PAD,
    WSP_LEN,
    WSP_WDIV,
    WSP_TRUNC,
    WSP_NEWPAL,
    WSP_CHUNK
  } wsp_state_t;

  // Slice header as handed to the chunk decoder
  typedef struct packed {
    logic [15:0] slice_length; // Slice length, already plus one
    logic [2:0] zdiv; // Zero-run divisor code
    logic zrun_on; // Zero-run compression in use
    logic [7:0] zrun_div; // Zero-run divisor value
    logic [2:0] wdiv; // Weight divisor code
    logic w_uncomp; // Uncompressed weight indices
    logic [7:0] w_div; // Weight divisor value
    logic wtrunc; // Truncated unary quotient
    logic newpal; // Palette reloaded for this slice
  } wsp_hdr_t;

  // Stream and companion stream locations
  typedef struct packed {
    logic [WSP_OFS_W-1:0] wgt_ofs;
    logic [WSP_WLEN_W-1:0] wgt_len;
    logic [WSP_OFS_W-1:0] scl_ofs;
    logic [WSP_SLEN_W-1:0] scl_len;
  } wsp_cmd_t;

  // Whole parser state
  typedef struct packed {
    wsp_state_t state;
    wsp_cmd_t cmd;
    logic [7:0] byte_buf; // Unread bits sit at the low end
    logic [3:0] bits_left; // Unread bits in byte_buf
    logic [WSP_WLEN_W-1:0] fetched; // Bytes taken so far
    logic [WSP_OFS_W-1:0] fetch_addr;
    logic byte_ready;
    logic [14:0] acc; // Element being assembled, LSB first
    logic [3:0] acc_cnt;
    wsp_hdr_t work; // Header being assembled
    wsp_hdr_t hdr; // Header of the live slice
    logic first_slice;
    logic slot_bit; // Bit offered to the chunk decoder
    logic slot_valid;
    logic slice_start;
    logic pal_reload;
    logic busy;
    logic done;
    logic err;
    logic [2:0] err_code;
  } wsp_regs_t;

endpackage

`default_nettype wire

//--- verif/wsp_parser_chk.sv
/*
  Concurrent checks on the ports of the weight stream slice parser.
  Assumes one clock, ref_clk_i, and a synchronous active-high srst_i.
*/
`default_nettype none

module wsp_parser_chk
  import wsp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic byte_ready_o,
  input wire logic byte_valid_i,
  input wire logic [WSP_OFS_W-1:0] fetch_addr_o,
  input wire logic chunk_bit_o,
  input wire logic chunk_valid_o,
  input wire logic chunk_ready_i,
  input wire logic slice_done_i,
  input wire wsp_hdr_t hdr_o,
  input wire logic slice_start_o,
  input wire logic pal_reload_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic err_o
);
  // One domain, so one clocking and one disable for all checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  a_ready_drop: assert property (byte_ready_o && byte_valid_i |=> !byte_ready_o)
    else $error("byte request held after a byte was taken");
  a_fetch_step: assert property (byte_ready_o && byte_valid_i |=>
    fetch_addr_o == $past(fetch_addr_o) + 48'h1) else $error("fetch address did not step");
  a_hdr_hold: assert property (busy_o && $past(busy_o) && !slice_start_o |->
    $stable(hdr_o)) else $error("header moved inside a slice");
  a_pal_pulse: assert property (pal_reload_o |-> slice_start_o && hdr_o.newpal)
    else $error("palette reload without new palette header");
  a_start_one: assert property (slice_start_o |=> !slice_start_o)
    else $error("slice start longer than one cycle");
  a_chunk_hold: assert property (chunk_valid_o && !chunk_ready_i && !slice_done_i |=>
    chunk_valid_o && $stable(chunk_bit_o)) else $error("offered chunk bit dropped");
  a_len_zrun: assert property (slice_start_o |-> hdr_o.slice_length != 16'h0000 &&
    hdr_o.zrun_on == (hdr_o.zdiv != WSP_ZDIV_NO_ZRUN)) else $error("bad slice header");
  a_wdiv_map: assert property (slice_start_o |->
    hdr_o.w_uncomp == (hdr_o.wdiv == WSP_WDIV_UNCOMP)) else $error("bad weight mode");
  a_busy_start: assert property (start_i && !busy_o |=> busy_o)
    else $error("start not taken");
  a_done_one: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_err_sticky: assert property (err_o && !start_i |=> err_o)
    else $error("error flag lost");
endmodule

bind wsp_parser wsp_parser_chk wsp_parser_chk_inst (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .start_i(start_i), .byte_ready_o(byte_ready_o),
  .byte_valid_i(byte_valid_i), .fetch_addr_o(fetch_addr_o), .chunk_bit_o(chunk_bit_o),
  .chunk_valid_o(chunk_valid_o), .chunk_ready_i(chunk_ready_i), .slice_done_i(slice_done_i),
  .hdr_o(hdr_o), .slice_start_o(slice_start_o), .pal_reload_o(pal_reload_o),
  .busy_o(busy_o), .done_o(done_o), .err_o(err_o));

`default_nettype wire

//--- verif/wsp_mem_model.sv
/*
  Memory holding a compiled weight stream, serving one byte per request.
  Assumes the bench fills mem and that fetch addresses sit near base_i.
*/
`default_nettype none

module wsp_mem_model
  import wsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WSP_OFS_W-1:0] addr_i,
  input wire logic [WSP_OFS_W-1:0] base_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255]; // Stream bytes, offset from base_i
  int seed = 32'h5f442d40; // Own seed, answer delay varies
  logic tk; // Byte taken at this edge

  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
  end

  // Answer promptly or after random wait; hold until taken
  always @(posedge clk_i) begin
    tk = valid_o & ready_i;
    #1;
    if (srst_i || tk) begin
      valid_o = 1'b0;
      data_o = ~data_o; // Released bus shows no stale byte
    end else if (ready_i && !valid_o && ($random(seed) & 1)) begin
      valid_o = 1'b1;
      data_o = mem[8'(addr_i - base_i)];
    end
  end
endmodule

`default_nettype wire

//--- verif/wsp_parser_tb_top.sv
/*
  Self-checking bench: builds streams bit by bit, serves them from the
  memory model and checks headers, chunk bits and error codes.
  Assumes the chunk decoder role is played here by the bench.
*/
`default_nettype none

module wsp_parser_tb_top
  import wsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Expected slice: chunk start, chunk count, header fields
  typedef struct packed {
    logic [15:0] cs;
    logic [7:0] cn;
    logic [14:0] len;
    logic [2:0] zd;
    logic [2:0] wd;
    logic tr;
    logic np;
  } wsp_slc_t;
  logic ref_clk_i = 0, srst_i = 1, start_i = 0, chunk_ready_i = 0, slice_done_i = 0;
  logic [WSP_OFS_W-1:0] wofs = 0, sofs = 0, fetch_addr_o, scale_offset_o;
  logic [31:0] wlen = 0;
  logic [19:0] slen = 0, scale_length_o;
  logic byte_valid_i, byte_ready_o, chunk_bit_o, chunk_valid_o, slice_start_o;
  logic pal_reload_o, busy_o, done_o, err_o;
  logic [7:0] byte_i;
  logic [2:0] err_code_o;
  wsp_hdr_t hdr_o;
  int fails = 0, n_tests = 0, seed = 32'h5f442d40;
  bit q[$]; // Stream bits in stream order
  wsp_slc_t eq[$];
  logic [2:0] ee_tab [8] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h4, 3'h2, 3'h5, 3'h6};

  always #2 ref_clk_i = ~ref_clk_i;

  wsp_parser wsp_parser_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .start_i(start_i),
    .second_weight_stream_offset_cmd_i(wofs), .second_weight_stream_length_cmd_i(wlen),
    .second_scale_stream_offset_cmd_i(sofs), .second_scale_stream_length_cmd_i(slen),
    .fetch_addr_o(fetch_addr_o), .byte_ready_o(byte_ready_o), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .chunk_bit_o(chunk_bit_o), .chunk_valid_o(chunk_valid_o),
    .chunk_ready_i(chunk_ready_i), .slice_done_i(slice_done_i), .hdr_o(hdr_o),
    .slice_start_o(slice_start_o), .pal_reload_o(pal_reload_o),
    .scale_offset_o(scale_offset_o), .scale_length_o(scale_length_o), .busy_o(busy_o),
    .done_o(done_o), .err_o(err_o), .err_code_o(err_code_o));
  wsp_mem_model wsp_mem_model_inst (.clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(fetch_addr_o),
    .base_i(wofs), .ready_i(byte_ready_o), .valid_o(byte_valid_i), .data_o(byte_i));

  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Elements go LSB first
  task automatic put(input logic [14:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
  endtask
  // Align code then one-bits up to the byte boundary
  task automatic align();
    put(15'h7, 3);
    while (q.size() % 8) q.push_back(1'b1);
  endtask
  task automatic slice(input logic [2:0] zd, input logic [2:0] wd, input logic np);
    wsp_slc_t s;
    s = '0;
    s.zd = zd;
    s.wd = wd;
    s.np = np;
    {s.len, s.tr} = 16'($random(seed));
    s.cn = 8'(1 + {$random(seed)} % 24);
    put(15'(zd), 3);
    put(s.len, 15);
    put(15'(wd), 3);
    put(15'(s.tr), 1);
    put(15'(np), 1);
    s.cs = 16'(q.size());
    for (int i = 0; i < s.cn; i++) q.push_back(1'($random(seed)));
    eq.push_back(s);
  endtask
  // Kind 0 good stream, others each carry one fault
  task automatic build(input int k);
    case (k)
      0: for (int s = 0; s < 7; s++) begin
        slice(s % 5 == 4 ? 3'h6 : 3'(s % 5), s == 6 ? 3'h7 : 3'(s), s == 0 || ($random(seed) & 1));
        if (s == 2) align();
      end
      1, 2: put(15'(k + 3), 3);
      3: begin put(15'h7, 3); q.push_back(1'b0); end
      4: slice(3'h0, 3'h0, 1'b0);
      5: slice(3'h1, 3'h6, 1'b1);
      6: put(15'h00F8, 8);
      default: slice(3'h2, 3'h3, 1'b1);
    endcase
    if (k != 6) begin
      align();
      while (q.size() % 128) put(15'h00FF, 8);
    end
  endtask
  task automatic run(input logic [2:0] ee, input int nb);
    wsp_slc_t s;
    int g, h, cnt;
    logic pv, pb;
    for (g = 0; g < q.size(); g++) wsp_mem_model_inst.mem[g / 8][g % 8] = q[g];
    wofs = 48'({$random(seed), $random(seed)});
    sofs = 48'({$random(seed), $random(seed)});
    slen = 20'($random(seed));
    wlen = 32'(nb);
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    chk(busy_o, 1'b1);
    for (g = 0; g < 20000 && !done_o; g++) begin
      if (slice_start_o) begin
        s = eq.pop_front();
        chk(hdr_o.slice_length, s.len + 16'h1);
        chk({hdr_o.zdiv, hdr_o.wdiv, hdr_o.wtrunc, hdr_o.newpal}, {s.zd, s.wd, s.tr, s.np});
        chk(pal_reload_o, s.np);
        chk(hdr_o.zrun_on, s.zd != 3'h6);
        chk(hdr_o.w_uncomp, s.wd == 3'h7);
        if (s.zd <= 3) chk(hdr_o.zrun_div, 8'h1 << s.zd);
        if (s.wd <= 5) chk(hdr_o.w_div, 8'h1 << s.wd);
        for (cnt = 0, h = 0; cnt < s.cn && h < 2000; h++) begin
          chunk_ready_i = 1'($random(seed));
          pv = chunk_valid_o & chunk_ready_i;
          pb = chunk_bit_o;
          tick();
          if (pv) chk(pb, q[s.cs + cnt++]);
        end
        if (cnt < s.cn) begin
          fails++;
          wrap_up();
        end
        chunk_ready_i = 1'b0;
        slice_done_i = 1'b1;
        tick();
        slice_done_i = 1'b0;
      end else tick();
    end
    if (g >= 20000) begin
      fails++;
      wrap_up();
    end
    chk(err_code_o, ee);
    chk(err_o, ee != 3'h0);
    chk({scale_offset_o, scale_length_o}, {sofs, slen});
    chk(eq.size(), 0);
    q.delete();
    eq.delete();
    tick();
  endtask

  // Reset, then every stream kind, the good one twice
  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    for (int k = 0; k < 9; k++) begin
      build(k % 8);
      run(ee_tab[k % 8], k % 8 == 6 ? 1 : q.size() / 8 - (k % 8 == 7));
    end
    wrap_up();
  end
endmodule

`default_nettype wire
